// *** rtl/pixel_lookup_table_consts.vh ***
`ifndef PIXEL_LOOKUP_TABLE_CONSTS_VH
`define PIXEL_LOOKUP_TABLE_CONSTS_VH

// ----------------------------------------
// Table geometry
// ----------------------------------------
`define PLT_IDX_W        11
`define PLT_VAL_W        9
`define PLT_ENTRIES      2048
`define PLT_IDX_MAX      11'h7ff
`define PLT_PIX_W        16
`define PLT_PIX_IDX_MAX  16'h07ff

// ----------------------------------------
// Data path buffer
// ----------------------------------------
`define PLT_FIFO_DEPTH   16
`define PLT_FIFO_AW      4
`define PLT_FIFO_CW      5

// ----------------------------------------
// Register map, byte addresses
// ----------------------------------------
`define PLT_ADR_W        14
`define PLT_REG_CONTROL  14'h0000
`define PLT_REG_SELECT   14'h0004
`define PLT_REG_INDEX    14'h0008
`define PLT_REG_VALUE    14'h000c
`define PLT_REG_STATUS   14'h0010
`define PLT_BULK_BIT     13

// ----------------------------------------
// Control and status fields
// ----------------------------------------
`define PLT_CTL_ENABLE   0
`define PLT_CTL_FMT_LO   1
`define PLT_CTL_FMT_HI   2
`define PLT_CTL_THREE    3
`define PLT_CTL_W        4
`define PLT_CTL_RESET    4'h0
`define PLT_FMT_8        2'h0
`define PLT_FMT_12       2'h1
`define PLT_FMT_16       2'h2
`define PLT_SEL_W        8
`define PLT_SEL_ONE      8'h00
`define PLT_STS_OUTV     0
`define PLT_STS_FIFO_LO  8
`define PLT_STS_FIFO_HI  12
`define PLT_STS_COMP_LO  16
`define PLT_STS_COMP_HI  17
`define PLT_COMP_FIRST   2'h0
`define PLT_COMP_LAST    2'h2

`endif

// *** rtl/pixel_lookup_table.v ***
`default_nettype none
`include "pixel_lookup_table_consts.vh"

// ----------------------------------------
// Pixel buffer
// ----------------------------------------
module pixel_fifo #(
  parameter WIDTH = `PLT_PIX_W,
  parameter DEPTH = `PLT_FIFO_DEPTH,
  parameter AW    = `PLT_FIFO_AW,
  parameter CW    = `PLT_FIFO_CW
) (
  input  wire             clk_i,       // Clock
  input  wire             rst_i,       // Sync reset
  input  wire             in_valid_i,  // Write request
  input  wire [WIDTH-1:0] in_data_i,   // Write data
  output wire             in_ready_o,  // Not full
  output wire             out_valid_o, // Not empty
  output wire [WIDTH-1:0] out_data_o,  // Head word
  input  wire             out_ready_i, // Pop request
  output wire [CW-1:0]    level_o      // Words held
);
  // Pointers wrap at DEPTH; the level needs one bit more
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0]    wr_q;
  reg [AW-1:0]    rd_q;
  reg [CW-1:0]    cnt_q;
  reg             nfull_q;
  reg             nempty_q;
  wire            push;
  wire            pop;
  reg  [CW-1:0]   cnt_d;

  // Handshake outputs straight from the flag flops
  assign push        = in_valid_i & nfull_q;
  assign pop         = out_ready_i & nempty_q;
  assign in_ready_o  = nfull_q;
  assign out_valid_o = nempty_q;
  assign out_data_o  = mem_q[rd_q];
  assign level_o     = cnt_q;

  // Next fill level
  always @* begin
    cnt_d = cnt_q;
    if (push & ~pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop & ~push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  // Storage write, no reset needed on data
  always @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  // Pointers and flags kept as flops so ready and valid are clean
  always @(posedge clk_i) begin
    if (rst_i) begin
      wr_q     <= {AW{1'b0}};
      rd_q     <= {AW{1'b0}};
      cnt_q    <= {CW{1'b0}};
      nfull_q  <= 1'b1;
      nempty_q <= 1'b0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q    <= cnt_d;
      nfull_q  <= (cnt_d != DEPTH[CW-1:0]);
      nempty_q <= (cnt_d != {CW{1'b0}});
    end
  end
endmodule

// Notes on behaviour
// - Each pixel indexes an eleven-bit-addressed table that yields a nine-bit value while the table is on.
// - A pixel above the largest eleven-bit index is clamped to that index before the lookup.
// - For eight-bit output the nine-bit result is rounded down to eight bits.
// - For twelve-bit output the result fills the top nine bits and the low three bits are zero.
// - For sixteen-bit output the result fills the top nine bits and the low seven bits are zero.
// - After reset every entry holds its own index divided by four.
// - The mapping works with every output format.
// - Only one user table exists and the selector accepts only that one choice.
// - A coefficient write changes the mapping at once, even while the table is on.
// - An index register picks the entry that the value register reads and writes.
// - A bulk window reaches every coefficient directly without the index register.
// - In three-component mode the red, green and blue words all pass through the one table.
// - In single-channel mode the stream is one channel mapped by the table.
// - Table contents live only in volatile flops and return to the linear table on reset.
module pixel_lookup_table (
  input  wire                    clk_i,       // 200 MHz clock
  input  wire                    rst_i,       // Sync reset, high
  input  wire                    wb_cyc_i,    // Bus cycle
  input  wire                    wb_stb_i,    // Bus strobe
  input  wire                    wb_we_i,     // Write enable
  input  wire [`PLT_ADR_W-1:0]   wb_adr_i,    // Byte address
  input  wire [3:0]              wb_sel_i,    // Byte lanes
  input  wire [31:0]             wb_dat_i,    // Write data
  output wire [31:0]             wb_dat_o,    // Read data
  output wire                    wb_ack_o,    // Acknowledge
  input  wire                    pix_valid_i, // Pixel offered
  input  wire [`PLT_PIX_W-1:0]   pix_data_i,  // Pixel value
  output wire                    pix_ready_o, // Buffer has room
  output wire                    out_valid_o, // Output word valid
  output wire [`PLT_PIX_W-1:0]   out_data_o,  // Formatted word
  output wire [1:0]              out_comp_o,  // Component tag
  input  wire                    out_ready_i  // Sink accepts
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------

  // Byte-lane merge for partial writes
  function [31:0] merge;
    input [31:0] old;
    input [31:0] dat;
    input [3:0]  sel;
    reg   [31:0] m;
    begin
      m     = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
      merge = (old & ~m) | (dat & m);
    end
  endfunction

  // Out-of-range pixels share the top entry
  function [`PLT_IDX_W-1:0] clamp;
    input [`PLT_PIX_W-1:0] p;
    begin
      if (p > `PLT_PIX_IDX_MAX) begin
        clamp = `PLT_IDX_MAX;
      end else begin
        clamp = p[`PLT_IDX_W-1:0];
      end
    end
  endfunction

  // Fit the nine-bit result to the selected width
  // The lowest bit is lost in eight-bit format; code 3 falls back to eight-bit
  function [`PLT_PIX_W-1:0] fit;
    input [`PLT_VAL_W-1:0] r;
    input [1:0]            fmt;
    begin
      case (fmt)
        `PLT_FMT_12: fit = {4'h0, r, 3'h0};
        `PLT_FMT_16: fit = {r, 7'h00};
        default:     fit = {8'h00, r[`PLT_VAL_W-1:1]};
      endcase
    end
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  // Table, control and output registers
  reg  [`PLT_VAL_W-1:0] table_q [0:`PLT_ENTRIES-1];
  reg  [`PLT_CTL_W-1:0] ctl_q;
  reg  [`PLT_SEL_W-1:0] table_select_q;
  reg  [`PLT_IDX_W-1:0] coefficient_index_q;
  reg                   ack_q;
  reg  [31:0]           rdat_q;
  reg                   out_valid_q;
  reg  [`PLT_PIX_W-1:0] out_data_q;
  reg  [1:0]            out_comp_q;
  reg  [1:0]            comp_q;
  reg  [1:0]            comp_d;
  reg  [31:0]           rdat_d;
  integer               i;

  // Bus decode; register offsets compare all fourteen address bits
  wire                  table_enable = ctl_q[`PLT_CTL_ENABLE];
  wire [1:0]            fmt          = ctl_q[`PLT_CTL_FMT_HI:`PLT_CTL_FMT_LO];
  wire                  three        = ctl_q[`PLT_CTL_THREE];
  wire                  hit          = wb_cyc_i & wb_stb_i & ~ack_q;
  wire                  wr           = hit & wb_we_i;
  wire                  bulk         = wb_adr_i[`PLT_BULK_BIT];
  wire [`PLT_IDX_W-1:0] bulk_idx     = wb_adr_i[`PLT_IDX_W+1:2];
  wire [31:0]           cur_value    = {23'h0, table_q[coefficient_index_q]};
  wire [31:0]           cur_bulk     = {23'h0, table_q[bulk_idx]};
  wire [31:0]           new_value    = merge(cur_value, wb_dat_i, wb_sel_i);
  wire [31:0]           new_bulk     = merge(cur_bulk, wb_dat_i, wb_sel_i);
  wire [31:0]           new_ctl      = merge({28'h0, ctl_q}, wb_dat_i, wb_sel_i);
  wire [31:0]           new_sel      = merge({24'h0, table_select_q}, wb_dat_i, wb_sel_i);
  wire [31:0]           new_idx      = merge({21'h0, coefficient_index_q}, wb_dat_i, wb_sel_i);

  // Output stage advances when empty or when the sink takes a word
  wire                  f_valid;
  wire [`PLT_PIX_W-1:0] f_data;
  wire [`PLT_FIFO_CW-1:0] f_level;
  wire                  adv          = ~out_valid_q | out_ready_i;
  wire                  take         = f_valid & adv;
  // Lookup reads the buffer head; a same-edge entry write shows on the next word
  wire [`PLT_VAL_W-1:0] looked_up    = table_q[clamp(f_data)];

  // Every output comes straight from a flop
  assign wb_dat_o    = rdat_q;
  assign wb_ack_o    = ack_q;
  assign out_valid_o = out_valid_q;
  assign out_data_o  = out_data_q;
  assign out_comp_o  = out_comp_q;

  // ----------------------------------------
  // Input buffer
  // ----------------------------------------
  // Sixteen words absorb sink stalls; the source must hold while not ready
  pixel_fifo #(
    .WIDTH (`PLT_PIX_W),
    .DEPTH (`PLT_FIFO_DEPTH),
    .AW    (`PLT_FIFO_AW),
    .CW    (`PLT_FIFO_CW)
  ) pixel_fifo_i (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (pix_valid_i),
    .in_data_i   (pix_data_i),
    .in_ready_o  (pix_ready_o),
    .out_valid_o (f_valid),
    .out_data_o  (f_data),
    .out_ready_i (adv),
    .level_o     (f_level)
  );

  // ----------------------------------------
  // Table storage
  // ----------------------------------------

  // Flops only, so contents never survive a reset; writes land at once
  always @(posedge clk_i) begin
    if (rst_i) begin
      // Linear default: entry n holds n/4
      for (i = 0; i < `PLT_ENTRIES; i = i + 1) begin
        table_q[i] <= i[`PLT_IDX_W-1:2];
      end
    end else if (wr & bulk) begin
      table_q[bulk_idx] <= new_bulk[`PLT_VAL_W-1:0];
    end else if (wr && (wb_adr_i == `PLT_REG_VALUE)) begin
      table_q[coefficient_index_q] <= new_value[`PLT_VAL_W-1:0];
    end
  end

  // ----------------------------------------
  // Register slave
  // ----------------------------------------

  // Read mux; unmapped words read zero
  always @* begin
    rdat_d = 32'h0;
    if (bulk) begin
      rdat_d = cur_bulk;
    end else if (wb_adr_i == `PLT_REG_CONTROL) begin
      rdat_d = {28'h0, ctl_q};
    end else if (wb_adr_i == `PLT_REG_SELECT) begin
      rdat_d = {24'h0, table_select_q};
    end else if (wb_adr_i == `PLT_REG_INDEX) begin
      rdat_d = {21'h0, coefficient_index_q};
    end else if (wb_adr_i == `PLT_REG_VALUE) begin
      rdat_d = cur_value;
    end else if (wb_adr_i == `PLT_REG_STATUS) begin
      // Snapshot only; nothing clears on read
      rdat_d[`PLT_STS_OUTV]                       = out_valid_q;
      rdat_d[`PLT_STS_FIFO_HI:`PLT_STS_FIFO_LO]   = f_level;
      rdat_d[`PLT_STS_COMP_HI:`PLT_STS_COMP_LO]   = comp_q;
    end
  end

  // One wait state per access; ack drops after one cycle
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_q               <= 1'b0;
      rdat_q              <= 32'h0;
      ctl_q               <= `PLT_CTL_RESET;
      table_select_q      <= `PLT_SEL_ONE;
      coefficient_index_q <= {`PLT_IDX_W{1'b0}};
    end else begin
      ack_q <= hit;
      if (hit & ~wb_we_i) begin
        rdat_q <= rdat_d;
      end
      // Writes land at the request edge, the same edge that raises ack
      if (wr & ~bulk) begin
        if (wb_adr_i == `PLT_REG_CONTROL) begin
          ctl_q <= new_ctl[`PLT_CTL_W-1:0];
        end else if (wb_adr_i == `PLT_REG_SELECT) begin
          // Any other choice is refused and the one table stays
          if (new_sel[`PLT_SEL_W-1:0] == `PLT_SEL_ONE) begin
            table_select_q <= `PLT_SEL_ONE;
          end
        end else if (wb_adr_i == `PLT_REG_INDEX) begin
          coefficient_index_q <= new_idx[`PLT_IDX_W-1:0];
        end
      end
    end
  end

  // ----------------------------------------
  // Pixel path
  // ----------------------------------------

  // Component counter; single-channel mode pins it at the first slot
  always @* begin
    comp_d = `PLT_COMP_FIRST;
    if (three && (comp_q != `PLT_COMP_LAST)) begin
      comp_d = comp_q + 1'b1;
    end
  end

  // Output register; the same table serves every component
  always @(posedge clk_i) begin
    if (rst_i) begin
      out_valid_q <= 1'b0;
      out_data_q  <= {`PLT_PIX_W{1'b0}};
      out_comp_q  <= `PLT_COMP_FIRST;
      comp_q      <= `PLT_COMP_FIRST;
    end else if (take) begin
      out_valid_q <= 1'b1;
      out_comp_q  <= comp_q;
      comp_q      <= comp_d;
      if (table_enable) begin
        out_data_q <= fit(looked_up, fmt);
      end else begin
        out_data_q <= f_data;
      end
    end else begin
      if (out_ready_i) begin
        out_valid_q <= 1'b0;
      end
      // Single-channel mode parks the tag at the first slot
      if (~three) begin
        comp_q <= `PLT_COMP_FIRST;
      end
    end
  end

endmodule

`default_nettype wire

// *** testbench/pixel_lookup_table_monitor.sv ***
`default_nettype none
`include "pixel_lookup_table_consts.vh"
module pixel_lookup_table_monitor (
  input wire logic        clk_i,       // Clock
  input wire logic        rst_i,       // Sync reset
  input wire logic        wb_cyc_i,    // Bus cycle
  input wire logic        wb_stb_i,    // Bus strobe
  input wire logic        wb_we_i,     // Write enable
  input wire logic [13:0] wb_adr_i,    // Byte address
  input wire logic [3:0]  wb_sel_i,    // Byte lanes
  input wire logic [31:0] wb_dat_i,    // Write data
  input wire logic [31:0] wb_dat_o,    // Read data
  input wire logic        wb_ack_o,    // Acknowledge
  input wire logic        out_valid_o, // Word valid
  input wire logic [15:0] out_data_o,  // Word
  input wire logic [1:0]  out_comp_o,  // Component tag
  input wire logic        out_ready_i  // Sink accepts
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] ctl_q; // Mirrored control

  // Mirror control writes; lags one cycle, so mode changes need an empty path
  always_ff @(posedge clk_i)
    if (rst_i) ctl_q <= 4'h0;
    else if (wb_ack_o && wb_we_i && wb_adr_i == `PLT_REG_CONTROL && wb_sel_i[0]) ctl_q <= wb_dat_i[3:0];

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ----------------------------------------
  // Bus and stream timing
  // ----------------------------------------
  property p_ack_timely; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_timely: assert property (p_ack_timely) else $error("ack missing");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_dat_hold; (!wb_ack_o || wb_we_i) |-> $stable(wb_dat_o); endproperty
  a_dat_hold: assert property (p_dat_hold) else $error("read data moved");
  property p_out_hold; out_valid_o && !out_ready_i |=> out_valid_o && $stable({out_data_o, out_comp_o}); endproperty
  a_out_hold: assert property (p_out_hold) else $error("word dropped");

  // ----------------------------------------
  // Output fitting and component tag
  // ----------------------------------------
  property p_fmt8; out_valid_o && ctl_q[0] && ctl_q[2:1] != 2'h1 && ctl_q[2:1] != 2'h2 |-> out_data_o[15:8] == 8'h00;
  endproperty
  a_fmt8: assert property (p_fmt8) else $error("8-bit word too wide");
  property p_fmt12; out_valid_o && ctl_q[0] && ctl_q[2:1] == 2'h1 |-> out_data_o[2:0] == 3'h0 && out_data_o[15:12] == 4'h0;
  endproperty
  a_fmt12: assert property (p_fmt12) else $error("12-bit word bad");
  property p_fmt16; out_valid_o && ctl_q[0] && ctl_q[2:1] == 2'h2 |-> out_data_o[6:0] == 7'h00; endproperty
  a_fmt16: assert property (p_fmt16) else $error("16-bit low bits set");
  property p_mono; out_valid_o && !ctl_q[3] |-> out_comp_o == 2'h0; endproperty
  a_mono: assert property (p_mono) else $error("tag in single mode");
endmodule
`default_nettype wire

// *** testbench/pixel_sink_model.sv ***
`default_nettype none
module pixel_sink_model (
  input  wire logic clk_i,   // Clock
  input  wire logic rst_i,   // Sync reset
  input  wire logic stall_i, // Hold off
  input  wire logic slow_i,  // Half rate
  output var logic  ready_o  // To block
);
  timeunit 1ns;
  timeprecision 1ps;

  // Stalls for as long as asked; slow mode accepts every other cycle
  always_ff @(posedge clk_i)
    if (rst_i) ready_o <= 1'b0;
    else ready_o <= !stall_i && (!slow_i || !ready_o);
endmodule
`default_nettype wire

// *** testbench/pixel_lookup_table_bench.sv ***
`default_nettype none
`include "pixel_lookup_table_consts.vh"
module pixel_lookup_table_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, stall, slow;
  logic        pix_valid_i, pix_ready_o, out_valid_o, out_ready_i;
  logic [13:0] wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, r;
  logic [15:0] pix_data_i, out_data_o;
  logic [1:0]  out_comp_o;
  logic [17:0] got[$];
  int          bad_count, comparisons;

  pixel_lookup_table pixel_lookup_table_i (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .wb_cyc_i    (wb_cyc_i),
    .wb_stb_i    (wb_stb_i),
    .wb_we_i     (wb_we_i),
    .wb_adr_i    (wb_adr_i),
    .wb_sel_i    (wb_sel_i),
    .wb_dat_i    (wb_dat_i),
    .wb_dat_o    (wb_dat_o),
    .wb_ack_o    (wb_ack_o),
    .pix_valid_i (pix_valid_i),
    .pix_data_i  (pix_data_i),
    .pix_ready_o (pix_ready_o),
    .out_valid_o (out_valid_o),
    .out_data_o  (out_data_o),
    .out_comp_o  (out_comp_o),
    .out_ready_i (out_ready_i)
  );
  pixel_sink_model pixel_sink_model_i (.clk_i(clk_i), .rst_i(rst_i), .stall_i(stall), .slow_i(slow),
                                       .ready_o(out_ready_i));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // Record every word the sink takes
  always @(posedge clk_i)
    if (out_valid_o === 1'b1 && out_ready_i === 1'b1) got.push_back({out_comp_o, out_data_o});

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task wrap_up;
    if (bad_count == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask

  // Classic cycle; idle edge afterwards so the next call never overlaps
  task wb(input logic w, input logic [13:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_sel_i <= s;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_dat_i <= ~d;
    @(posedge clk_i);
  endtask

  task rd(input logic [13:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(r, e);
  endtask

  task push(input logic [15:0] d);
    pix_valid_i <= 1'b1;
    pix_data_i <= d;
    @(posedge clk_i);
    while (pix_ready_o !== 1'b1) @(posedge clk_i);
  endtask

  // Release the source lines and wait for n words
  task settle(input int n);
    pix_valid_i <= 1'b0;
    pix_data_i <= ~pix_data_i;
    repeat (40) if (got.size() < n) @(posedge clk_i);
    chk(got.size(), n);
  endtask

  function automatic logic [31:0] fit(input logic [8:0] v, input int f);
    return f == 1 ? {20'h0, v, 3'h0} : f == 2 ? {16'h0, v, 7'h00} : {24'h0, v[8:1]};
  endfunction

  task do_reset;
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_defaults;
    rd(`PLT_REG_CONTROL, 32'h0);
    rd(`PLT_REG_VALUE, 32'h0);
    for (int i = 0; i < 2048; i += 341) rd(14'(14'h2000 + i * 4), 32'(i >> 2));
    rd(14'h3ffc, 32'h1ff);
    rd(14'h0020, 32'h0);
    wb(1'b1, `PLT_REG_SELECT, 32'h1);
    rd(`PLT_REG_SELECT, 32'h0);
  endtask

  task t_entries;
    wb(1'b1, `PLT_REG_INDEX, 32'h7ff);
    wb(1'b1, `PLT_REG_VALUE, 32'h1ab);
    rd(`PLT_REG_VALUE, 32'h1ab);
    rd(14'h3ffc, 32'h1ab);
    wb(1'b1, 14'h2014, 32'h0aa);
    wb(1'b1, `PLT_REG_INDEX, 32'h5);
    rd(`PLT_REG_VALUE, 32'h0aa);
    wb(1'b1, `PLT_REG_INDEX, 32'h3ff, 4'h1);
    rd(`PLT_REG_INDEX, 32'h0ff);
  endtask

  // Index 0x800 must clamp to the last entry, not wrap to entry 0
  task t_formats;
    for (int f = 0; f < 4; f++) begin
      wb(1'b1, `PLT_REG_CONTROL, 32'(f * 2 + 1));
      got.delete();
      push(16'h0800);
      push(16'h0005);
      settle(2);
      chk(got[0], fit(9'h1ab, f));
      chk(got[1], fit(9'h0aa, f));
    end
    wb(1'b1, 14'h2014, 32'h155);
    got.delete();
    push(16'h0005);
    settle(1);
    chk(got[0], fit(9'h155, 0));
  endtask

  task t_three;
    wb(1'b1, `PLT_REG_CONTROL, 32'h9);
    slow <= 1'b1;
    got.delete();
    for (int i = 0; i < 6; i++) push(i[0] ? 16'h0800 : 16'h0005);
    settle(6);
    for (int i = 0; i < 6; i++) chk(got[i], fit(i[0] ? 9'h1ab : 9'h155, 0) | 32'((i % 3) << 16));
    slow <= 1'b0;
  endtask

  // Stalled sink: output register plus sixteen buffered words
  task t_fill;
    wb(1'b1, `PLT_REG_CONTROL, 32'h0);
    stall <= 1'b1;
    @(posedge clk_i);
    got.delete();
    for (int i = 0; i < 17; i++) push(16'h1230 + 16'(i));
    pix_valid_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk(pix_ready_o, 32'h0);
    rd(`PLT_REG_STATUS, 32'h1001);
    stall <= 1'b0;
    settle(17);
    for (int i = 0; i < 17; i++) chk(got[i], 32'h1230 + i);
  endtask

  task t_reset_again;
    do_reset();
    rd(14'h3ffc, 32'h1ff);
    rd(14'h2014, 32'h1);
  endtask

  // Whole run needs about 180 cycles; 4000 leaves margin
  initial begin
    #20000;
    bad_count++;
    wrap_up();
  end

  initial begin
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, pix_valid_i, stall, slow} = 7'h40;
    wb_adr_i = 14'h0;
    wb_sel_i = 4'hf;
    wb_dat_i = 32'h0;
    pix_data_i = 16'h0;
    do_reset();
    t_defaults();
    t_entries();
    t_formats();
    t_three();
    t_fill();
    t_reset_again();
    wrap_up();
  end
endmodule

bind pixel_lookup_table pixel_lookup_table_monitor pixel_lookup_table_monitor_i (
  .clk_i       (clk_i),
  .rst_i       (rst_i),
  .wb_cyc_i    (wb_cyc_i),
  .wb_stb_i    (wb_stb_i),
  .wb_we_i     (wb_we_i),
  .wb_adr_i    (wb_adr_i),
  .wb_sel_i    (wb_sel_i),
  .wb_dat_i    (wb_dat_i),
  .wb_dat_o    (wb_dat_o),
  .wb_ack_o    (wb_ack_o),
  .out_valid_o (out_valid_o),
  .out_data_o  (out_data_o),
  .out_comp_o  (out_comp_o),
  .out_ready_i (out_ready_i)
);
`default_nettype wire
